// ===== design/pic_ctrl.sv
// Eight-level priority interrupt controller with cascade addressing
`timescale 1ns/1ps
`include "pic_map.svh"

// Notes on behaviour
// R1: interrupt processor, vector for top request
// R2: cascade addresses only for cascade levels
// R3: drive 3-bit slave address during acknowledge
// R4: slave drives vector on second strobe
// R5: two offsets carry all words
// R6: every transfer is one byte
// R7: software writes two to four init words
// R8: first word's low bits select words three/four
// R9: fourth-word flag expects the options word
// R10: third-word flag low expects cascade word
// R11: trigger select: level when 1, edge when 0
// R12: vector bits 7:3 from base word
// R13: cascade word bit n marks level n
// R14: self-finish bit clears service automatically
// R15: without self-finish software sends end-of-service
// R16: operation words accepted in any order
// R17: mask bit 1 blocks acknowledge of input
// R18: masked request pends, never enters service
// R19: offset 1 read returns mask
// R20: priority word sets rotation and finish method
// R21: mode bit 1 enables status, bit 0 picks
// R22: poll bit overrides status select
// R23: poll word: any flag, top level field
// R24: selected status word persists across reads
// R25: first init word restarts configuration
// R26: acknowledge sets service, clears pending (level mode: pending keeps following the input)
module pic_ctrl (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       bus_cs,
  input  wire logic       bus_addr,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  input  wire logic [7:0] request_inputs,
  output logic            int_req,
  input  wire logic       acknowledge_strobe_n,
  output logic      [7:0] vector_data,
  output logic            vector_oe,
  output logic            backplane_ack_n,
  output logic      [2:0] cascade_address_lines,
  output logic            cascade_oe
);
  pic_prio_if pif ();

  pic_pkg::pic_init_t st_q;        // Initialization progress
  pic_pkg::pic_ack_t  ackst_q;     // Acknowledge sequence phase
  logic [7:0]         irr_q;       // Pending requests
  logic [7:0]         isr_q;       // Levels in service
  logic [7:0]         isr_set;     // Bits entering service
  logic [7:0]         isr_clr;     // Bits leaving service
  logic [7:0]         mask_q;      // Request mask
  logic [4:0]         base_q;      // Vector upper bits
  logic [7:0]         casc_q;      // Cascade levels
  logic               sfi_q;       // Self finish enable
  logic               trig_q;      // Level triggered when set
  logic               fourth_q;    // Options word expected
  logic               skip3_q;     // Cascade word skipped
  pic_pkg::pic_lvl_t  lowest_q;    // Lowest priority level
  pic_pkg::pic_lvl_t  lowest_d;
  pic_pkg::pic_lvl_t  eoi_lvl;     // Level hit by finish command
  logic               auto_rot_q;  // Rotate on self finish
  logic               sel_q;       // Status select: 1 in-service
  logic               pol_q;       // Poll word selected
  logic [7:0]         req_prev_q;  // Inputs one cycle ago
  logic               ack_prev_q;  // Strobe one cycle ago
  pic_pkg::pic_lvl_t  ack_lvl_q;   // Level being acknowledged
  logic               ack_hit_q;   // Acknowledge found a request
  logic [7:0]         rdata_q;
  logic [7:0]         vec_q;
  logic               vec_oe_q;
  logic [2:0]         cas_q;
  logic               cas_oe_q;
  logic               wr0, wr1, wr_iw1, wr_pf, wr_md, rd0, rd1;
  logic               ack_fall, ack_rise, take, first, fin_auto;
  logic               ready;
  logic [7:0]         poll_word;

  pic_resolver u_res (.pif(pif));

  // Byte-wide port decode; the offset-0 pattern picks the word
  assign wr0    = bus_cs && bus_wr && bus_addr == `PIC_OFS_CMD; // [R5] [R6]
  assign wr1    = bus_cs && bus_wr && bus_addr == `PIC_OFS_DATA;
  assign rd0    = bus_cs && bus_rd && bus_addr == `PIC_OFS_CMD;
  assign rd1    = bus_cs && bus_rd && bus_addr == `PIC_OFS_DATA;
  assign wr_iw1 = wr0 && bus_wdata[`PIC_IW1_BIT]; // [R25]
  assign wr_pf  = wr0 && ready &&
    bus_wdata[`PIC_OPW_HI:`PIC_OPW_LO] == `PIC_OPW_PRIO; // [R16]
  assign wr_md  = wr0 && ready &&
    bus_wdata[`PIC_OPW_HI:`PIC_OPW_LO] == `PIC_OPW_MODE;
  assign ready  = st_q == pic_pkg::PIC_ST_READY;

  // Strobe edges from the processor's acknowledge pulses
  assign ack_fall = ack_prev_q && !acknowledge_strobe_n;
  assign ack_rise = !ack_prev_q && acknowledge_strobe_n;
  assign first = ready && ackst_q == pic_pkg::PIC_ACK_IDLE && ack_fall;
  assign take  = first && pif.grant; // [R17]
  assign fin_auto = ackst_q == pic_pkg::PIC_ACK_P2 && ack_rise &&
                    ack_hit_q && sfi_q; // [R14]

  assign pif.pend   = irr_q;
  assign pif.cand   = irr_q & ~mask_q; // [R18]
  assign pif.isr    = isr_q;
  assign pif.lowest = lowest_q;

  // Interrupt held while an unmasked request outranks the service
  assign int_req = ready && pif.grant; // [R1]

  // Poll word: flag on top, level in the low bits
  assign poll_word = {pif.poll_any, 4'h0, pif.poll_lvl}; // [R23]

  assign bus_rdata             = rdata_q;
  assign vector_data           = vec_q;
  assign vector_oe             = vec_oe_q;
  assign cascade_address_lines = cas_q;
  assign cascade_oe            = cas_oe_q;
  // Backplane strobe follows the processor only on cascade cycles
  assign backplane_ack_n = !(cas_oe_q && !acknowledge_strobe_n); // [R3]

  // Initialization sequence; a first word always restarts it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q     <= pic_pkg::PIC_ST_UNINIT;
      fourth_q <= 1'b0;
      skip3_q  <= 1'b1;
      trig_q   <= 1'b0;
    end else if (wr_iw1) begin
      fourth_q <= bus_wdata[`PIC_IW1_FOURTH]; // [R8] [R9]
      skip3_q  <= bus_wdata[`PIC_IW1_SKIP3];  // [R10]
      trig_q   <= bus_wdata[`PIC_IW1_TRIG];   // [R11]
      st_q     <= pic_pkg::PIC_ST_W2;
    end else if (wr1) begin
      case (st_q)
        pic_pkg::PIC_ST_W2: begin
          if (!skip3_q) begin
            st_q <= pic_pkg::PIC_ST_W3; // [R10]
          end else if (fourth_q) begin
            st_q <= pic_pkg::PIC_ST_W4; // [R9]
          end else begin
            st_q <= pic_pkg::PIC_ST_READY;
          end
        end
        pic_pkg::PIC_ST_W3: begin
          st_q <= fourth_q ? pic_pkg::PIC_ST_W4 : pic_pkg::PIC_ST_READY;
        end
        pic_pkg::PIC_ST_W4: st_q <= pic_pkg::PIC_ST_READY;
        default: st_q <= st_q; // Ready or idle: no step
      endcase
    end
  end

  // Offset-1 words: base, cascade levels, options, then mask
  always_ff @(posedge clk) begin
    if (!reset_n || wr_iw1) begin
      base_q <= `PIC_RST_BASE;
      casc_q <= 8'h00;
      sfi_q  <= 1'b0;
      mask_q <= `PIC_RST_MASK; // [R25]
    end else if (wr1) begin
      case (st_q)
        pic_pkg::PIC_ST_W2: base_q <= bus_wdata[7:3]; // [R12]
        pic_pkg::PIC_ST_W3: casc_q <= bus_wdata;      // [R13]
        pic_pkg::PIC_ST_W4: sfi_q  <= bus_wdata[`PIC_IW4_SFI]; // [R14]
        pic_pkg::PIC_ST_READY: mask_q <= bus_wdata;   // [R16] [R17]
        default: mask_q <= mask_q; // Mask writes before setup ignored
      endcase
    end
  end

  // Mode word: poll flag and sticky status select
  always_ff @(posedge clk) begin
    if (!reset_n || wr_iw1) begin
      pol_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (wr_md) begin
      pol_q <= bus_wdata[`PIC_MD_POL]; // [R22]
      if (bus_wdata[`PIC_MD_SR]) begin
        sel_q <= bus_wdata[`PIC_MD_SEL]; // [R21] [R24]
      end
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (rd1) begin
      rdata_q <= mask_q; // [R19]
    end else if (rd0) begin
      if (pol_q) begin
        rdata_q <= poll_word; // [R22]
      end else begin
        rdata_q <= sel_q ? isr_q : irr_q; // [R21] [R24]
      end
    end
  end

  // Pending requests: level mode follows inputs, edge mode latches
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irr_q      <= 8'h00;
      req_prev_q <= 8'h00;
    end else begin
      req_prev_q <= request_inputs;
      if (wr_iw1) begin
        irr_q <= 8'h00;
      end else if (trig_q) begin
        irr_q <= request_inputs; // [R11]
      end else begin
        // New edge wins over the clear of an acknowledge
        irr_q <= (irr_q & ~isr_set) |
                 (request_inputs & ~req_prev_q); // [R11] [R26]
      end
    end
  end

  // Service bits and rotation from commands and acknowledges
  always_comb begin
    isr_set  = 8'h00;
    isr_clr  = 8'h00;
    lowest_d = lowest_q;
    eoi_lvl  = bus_wdata[`PIC_PF_SIL] ? bus_wdata[2:0] : pif.isr_lvl;
    if (take) begin
      isr_set[pif.cand_lvl] = 1'b1; // [R26]
    end
    if (wr_pf) begin
      if (bus_wdata[`PIC_PF_FI]) begin
        // Specific or non-specific end of service
        if (bus_wdata[`PIC_PF_SIL] || pif.isr_any) begin
          isr_clr[eoi_lvl] = 1'b1; // [R15] [R20] [R26]
        end
        if (bus_wdata[`PIC_PF_RP]) begin
          lowest_d = eoi_lvl; // [R20]
        end
      end else if (bus_wdata[`PIC_PF_RP] && bus_wdata[`PIC_PF_SIL]) begin
        lowest_d = bus_wdata[2:0]; // [R20]
      end
    end
    if (fin_auto) begin
      isr_clr[ack_lvl_q] = 1'b1; // [R14]
      if (auto_rot_q) begin
        lowest_d = ack_lvl_q;
      end
    end
  end

  // Service register and priority state; entry wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n || wr_iw1) begin
      isr_q      <= 8'h00;
      lowest_q   <= `PIC_RST_LOWEST;
      auto_rot_q <= 1'b0;
    end else begin
      isr_q    <= (isr_q & ~isr_clr) | isr_set; // [R26]
      lowest_q <= lowest_d;
      if (wr_pf && !bus_wdata[`PIC_PF_FI] && !bus_wdata[`PIC_PF_SIL]) begin
        auto_rot_q <= bus_wdata[`PIC_PF_RP]; // [R20]
      end
    end
  end

  // Two-pulse acknowledge: level latched on first, vector on second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ackst_q    <= pic_pkg::PIC_ACK_IDLE;
      ack_prev_q <= 1'b1;
      ack_lvl_q  <= 3'h7;
      ack_hit_q  <= 1'b0;
      vec_q      <= 8'h00;
      vec_oe_q   <= 1'b0;
      cas_q      <= 3'h0;
      cas_oe_q   <= 1'b0;
    end else begin
      ack_prev_q <= acknowledge_strobe_n;
      case (ackst_q)
        pic_pkg::PIC_ACK_IDLE: begin
          if (first) begin
            // No winner: spurious cycle answers with level 7
            ackst_q   <= pic_pkg::PIC_ACK_P1;
            ack_hit_q <= pif.grant;
            ack_lvl_q <= pif.grant ? pif.cand_lvl : 3'h7; // [R1]
            if (pif.grant && casc_q[pif.cand_lvl]) begin
              cas_q    <= pif.cand_lvl; // [R2] [R3]
              cas_oe_q <= 1'b1;
            end
          end
        end
        pic_pkg::PIC_ACK_P1: begin
          if (ack_rise) begin
            ackst_q <= pic_pkg::PIC_ACK_GAP;
          end
        end
        pic_pkg::PIC_ACK_GAP: begin
          if (ack_fall) begin
            ackst_q  <= pic_pkg::PIC_ACK_P2;
            vec_q    <= {base_q, ack_lvl_q}; // [R12]
            vec_oe_q <= !cas_oe_q; // Slave answers instead [R4]
          end
        end
        pic_pkg::PIC_ACK_P2: begin
          if (ack_rise) begin
            ackst_q  <= pic_pkg::PIC_ACK_IDLE;
            vec_oe_q <= 1'b0;
            cas_oe_q <= 1'b0;
          end
        end
        default: ackst_q <= pic_pkg::PIC_ACK_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Waiting for the base word of a two-word setup
  sequence s_iw1_short;
    st_q == pic_pkg::PIC_ST_W2 && skip3_q && !fourth_q;
  endsequence
  sequence s_take;
    take && !casc_q[pif.cand_lvl];
  endsequence

  // Base word alone completes a short setup, whatever the bus spacing
  property p_short_init;
    s_iw1_short ##0 wr1 |=> ready;
  endproperty
  a_short_init: assert property (p_short_init) // [R8] [R10]
    else $error("short init did not reach ready");

  // Strobe lengths vary, so the second pulse is allowed a bounded window
  property p_vec_base;
    s_take ##[1:40] $rose(vec_oe_q)
      |-> vec_q[7:3] == base_q && vec_q[2:0] == ack_lvl_q;
  endproperty
  a_vec_base: assert property (p_vec_base) // [R12]
    else $error("vector upper bits differ from base");

  property p_mask_read;
    rd1 |=> rdata_q == $past(mask_q);
  endproperty
  a_mask_read: assert property (p_mask_read) // [R19]
    else $error("mask readback wrong");

  property p_masked_no_service;
    (isr_q & ~$past(isr_q) & $past(mask_q)) == 8'h00;
  endproperty
  a_masked_no_service: assert property (p_masked_no_service) // [R18]
    else $error("masked level entered service");

  property p_poll_empty;
    rd0 && pol_q && irr_q == 8'h00 |=> rdata_q == 8'h07;
  endproperty
  a_poll_empty: assert property (p_poll_empty) // [R23]
    else $error("empty poll word wrong");

  property p_casc_only;
    cas_oe_q |-> casc_q[cas_q] && !vec_oe_q;
  endproperty
  a_casc_only: assert property (p_casc_only) // [R2]
    else $error("cascade address on ordinary level");

  property p_take_sets;
    take |=> isr_q[ack_lvl_q] && ackst_q == pic_pkg::PIC_ACK_P1;
  endproperty
  a_take_sets: assert property (p_take_sets) // [R26]
    else $error("acknowledge did not set service");

  property p_self_finish;
    fin_auto |=> !isr_q[ack_lvl_q] && ackst_q == pic_pkg::PIC_ACK_IDLE;
  endproperty
  a_self_finish: assert property (p_self_finish) // [R14]
    else $error("self finish left service set");

  property p_level_follow;
    trig_q && !wr_iw1 |=> irr_q == $past(request_inputs);
  endproperty
  a_level_follow: assert property (p_level_follow) // [R11]
    else $error("level mode pending mismatch");

  property p_status_sel;
    rd0 && !pol_q && sel_q |=> rdata_q == $past(isr_q);
  endproperty
  a_status_sel: assert property (p_status_sel) // [R21] [R24]
    else $error("in-service read wrong");
endmodule

// ===== design/pic_map.svh
// Offsets, field positions and reset values of the interrupt controller
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
`define PIC_OFS_CMD    1'b0
`define PIC_OFS_DATA   1'b1
`define PIC_IW1_BIT    4
`define PIC_OPW_HI     4
`define PIC_OPW_LO     3
`define PIC_OPW_PRIO   2'b00
`define PIC_OPW_MODE   2'b01
`define PIC_IW1_FOURTH 0
`define PIC_IW1_SKIP3  1
`define PIC_IW1_TRIG   3
`define PIC_IW4_SFI    1
`define PIC_PF_RP      7
`define PIC_PF_SIL     6
`define PIC_PF_FI      5
`define PIC_MD_SEL     0
`define PIC_MD_SR      1
`define PIC_MD_POL     2
`define PIC_POLL_INT   7
`define PIC_RST_MASK   8'h00
`define PIC_RST_BASE   5'h00
`define PIC_RST_LOWEST 3'h7
`endif

// ===== design/pic_pkg.sv
// Types shared by the interrupt controller modules
package pic_pkg;
  typedef logic [2:0] pic_lvl_t;
  typedef enum logic [2:0] {
    PIC_ST_UNINIT = 3'h0,
    PIC_ST_W2     = 3'h1,
    PIC_ST_W3     = 3'h2,
    PIC_ST_W4     = 3'h3,
    PIC_ST_READY  = 3'h4
  } pic_init_t;
  typedef enum logic [1:0] {
    PIC_ACK_IDLE = 2'h0,
    PIC_ACK_P1   = 2'h1,
    PIC_ACK_GAP  = 2'h2,
    PIC_ACK_P2   = 2'h3
  } pic_ack_t;
endpackage

// ===== design/pic_prio_if.sv
// Carrier between the controller and its priority resolver
`timescale 1ns/1ps
interface pic_prio_if;
  logic [7:0]        pend;     // Raw pending requests
  logic [7:0]        cand;     // Pending and unmasked
  logic [7:0]        isr;      // In-service levels
  pic_pkg::pic_lvl_t lowest;   // Level with lowest priority
  logic              poll_any; // Any raw request
  pic_pkg::pic_lvl_t poll_lvl; // Top raw request, 7 when none
  logic              cand_any; // Any unmasked request
  pic_pkg::pic_lvl_t cand_lvl; // Top unmasked request
  logic              isr_any;  // Any level in service
  pic_pkg::pic_lvl_t isr_lvl;  // Top level in service
  logic              grant;    // Candidate outranks service
  modport ctrl (output pend, cand, isr, lowest,
                input poll_any, poll_lvl, cand_any, cand_lvl,
                isr_any, isr_lvl, grant);
  modport res (input pend, cand, isr, lowest,
               output poll_any, poll_lvl, cand_any, cand_lvl,
               isr_any, isr_lvl, grant);
endinterface

// ===== design/pic_resolver.sv
// Priority resolver: rotating search over eight levels
`timescale 1ns/1ps
module pic_resolver (
  pic_prio_if.res pif
);
  // First set bit, searching upward from the level after the lowest
  function automatic logic [3:0] first_set(input logic [7:0] v,
                                           input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] idx;
    r = {1'b0, 3'h7}; // None found: flag clear, level field reads as 7
    for (int i = 7; i >= 0; i--) begin
      idx = 3'(low + 3'(i) + 3'h1);
      if (v[idx]) begin
        r = {1'b1, idx}; // Later loop steps rank higher
      end
    end
    return r;
  endfunction

  // Rank 0 is the highest priority under the current rotation
  function automatic logic [2:0] rank(input logic [2:0] lvl,
                                      input logic [2:0] low);
    return 3'(lvl - low - 3'h1);
  endfunction

  assign {pif.poll_any, pif.poll_lvl} = first_set(pif.pend, pif.lowest);
  assign {pif.cand_any, pif.cand_lvl} = first_set(pif.cand, pif.lowest);
  assign {pif.isr_any, pif.isr_lvl}   = first_set(pif.isr, pif.lowest);

  // A request only interrupts a service of lower priority
  assign pif.grant = pif.cand_any &&
    (!pif.isr_any ||
     rank(pif.cand_lvl, pif.lowest) < rank(pif.isr_lvl, pif.lowest));
endmodule

// ===== bench/pic_host_model.sv
// Processor acknowledge sequencer with a cascaded slave stand-in
`timescale 1ns/1ps
module pic_host_model #(
  parameter logic [4:0] SLAVE_BASE = 5'h1c  // Slave vector base, arbitrary
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       slow,
  output logic            done,
  output logic            acknowledge_strobe_n,
  input  wire logic [7:0] vector_data,
  input  wire logic       vector_oe,
  input  wire logic       backplane_ack_n,
  input  wire logic [2:0] cascade_address_lines,
  input  wire logic       cascade_oe,
  output logic            vec_seen,
  output logic      [7:0] vec_val,
  output logic            casc_seen,
  output logic      [2:0] casc_addr
);
  logic [1:0] phase;  // 1 first pulse, 2 second pulse, 0 otherwise
  int         len;    // Cycles per strobe level

  // One cycle of watching the controller, just after the edge settles
  task automatic step();
    @(posedge clk);
    #1;
    if (vector_oe === 1'b1) begin
      vec_seen = 1'b1;
      vec_val  = vector_data;
    end
    // Slave answers only on the second pulse it is addressed in
    if (phase == 2'd2 && cascade_oe === 1'b1 &&
        backplane_ack_n === 1'b0) begin
      casc_seen = 1'b1;
      casc_addr = cascade_address_lines;
      vec_val   = {SLAVE_BASE, cascade_address_lines};
    end
  endtask

  // Two strobe pulses per request; slow mode stretches every level
  initial begin
    acknowledge_strobe_n = 1'b1;
    done      = 1'b0;
    phase     = 2'd0;
    vec_seen  = 1'b0;
    vec_val   = 8'h00;
    casc_seen = 1'b0;
    casc_addr = 3'h0;
    forever begin
      @(posedge clk);
      if (go === 1'b1 && !done) begin
        #1;
        vec_seen  = 1'b0;
        casc_seen = 1'b0;
        len = slow ? 4 : 2;
        phase = 2'd1;
        acknowledge_strobe_n = 1'b0;
        repeat (len) step();
        phase = 2'd0;
        acknowledge_strobe_n = 1'b1;  // Gap between pulses
        repeat (len) step();
        phase = 2'd2;
        acknowledge_strobe_n = 1'b0;
        repeat (len) step();
        phase = 2'd0;
        acknowledge_strobe_n = 1'b1;
        repeat (3) step();  // Let drivers drop before reporting
        done = 1'b1;
      end else if (go !== 1'b1) begin
        done = 1'b0;
      end
    end
  end
endmodule

// ===== bench/pic_ctrl_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module pic_ctrl_tb;
  logic       clk;
  logic       reset_n;
  logic       bus_cs;
  logic       bus_addr;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic [7:0] request_inputs;
  logic       int_req;
  logic       acknowledge_strobe_n;
  logic [7:0] vector_data;
  logic       vector_oe;
  logic       backplane_ack_n;
  logic [2:0] cascade_address_lines;
  logic       cascade_oe;
  logic       ack_go;     // Start an acknowledge sequence
  logic       ack_slow;   // Stretch strobe levels
  logic       ack_done;   // Sequence finished
  logic       vec_seen;   // Controller drove its own vector
  logic [7:0] vec_val;    // Vector byte collected
  logic       casc_seen;  // Slave was addressed
  logic [2:0] casc_addr;  // Slave address seen
  int         err_total;
  int         total_checks;

  pic_ctrl u_pic_ctrl (
    .clk(clk), .reset_n(reset_n), .bus_cs(bus_cs), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .request_inputs(request_inputs),
    .int_req(int_req), .acknowledge_strobe_n(acknowledge_strobe_n),
    .vector_data(vector_data), .vector_oe(vector_oe),
    .backplane_ack_n(backplane_ack_n),
    .cascade_address_lines(cascade_address_lines),
    .cascade_oe(cascade_oe)
  );

  pic_host_model u_pic_host_model (
    .clk(clk), .go(ack_go), .slow(ack_slow), .done(ack_done),
    .acknowledge_strobe_n(acknowledge_strobe_n),
    .vector_data(vector_data), .vector_oe(vector_oe),
    .backplane_ack_n(backplane_ack_n),
    .cascade_address_lines(cascade_address_lines),
    .cascade_oe(cascade_oe), .vec_seen(vec_seen), .vec_val(vec_val),
    .casc_seen(casc_seen), .casc_addr(casc_addr)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out();
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare one byte and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One byte write; strobes drop before the next access starts
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_cs    = 1'b1;
    bus_wr    = 1'b1;
    bus_addr  = a;
    bus_wdata = d;
    @(posedge clk);
    #1;
    bus_cs = 1'b0;
    bus_wr = 1'b0;
  endtask

  // One byte read; data is registered at the taking edge
  task automatic rd(input logic a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    bus_cs   = 1'b1;
    bus_rd   = 1'b1;
    bus_addr = a;
    @(posedge clk);
    #1;
    bus_cs = 1'b0;
    bus_rd = 1'b0;
    chk(bus_rdata, exp);
  endtask

  // Wait a bounded time for the interrupt line to reach a level
  task automatic wait_int(input logic exp);
    int n;
    n = 0;
    while (int_req !== exp && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, int_req}, {7'h00, exp});
    // A line that never settles ends the run
    if (int_req !== exp) begin
      close_out();
    end
  endtask

  // Run a full two-pulse acknowledge through the host model
  task automatic ack(input logic s);
    int n;
    @(posedge clk);
    #1;
    ack_slow = s;
    ack_go   = 1'b1;
    n = 0;
    while (ack_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    #1;
    ack_go = 1'b0;
    if (ack_done !== 1'b1) begin
      err_total++;
      close_out();
    end
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    total_checks = 0;
    reset_n = 1'b0;
    bus_cs = 1'b0;
    bus_addr = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
    request_inputs = 8'h00;
    ack_go = 1'b0;
    ack_slow = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk({7'h00, int_req}, 8'h00);
    rd(1'b0, 8'h00);
    // Init: fourth word expected, cascade word expected, edge mode
    wr(1'b0, 8'h11);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h04);  // Level 2 is a cascade level
    wr(1'b1, 8'h00);  // Options: no self finish
    rd(1'b1, 8'h00);
    wr(1'b1, 8'ha5);
    rd(1'b1, 8'ha5);
    wr(1'b1, 8'h00);
    // Ordinary level 5, edge triggered
    request_inputs = 8'h20;
    wait_int(1'b1);
    rd(1'b0, 8'h20);
    ack(1'b0);
    chk({7'h00, vec_seen}, 8'h01);
    chk(vec_val, 8'h45);
    chk({7'h00, casc_seen}, 8'h00);
    wr(1'b0, 8'h0b);
    rd(1'b0, 8'h20);
    rd(1'b0, 8'h20);
    wr(1'b0, 8'h0a);
    rd(1'b0, 8'h00);
    request_inputs = 8'h00;
    wr(1'b0, 8'h20);  // End of service
    wr(1'b0, 8'h0b);
    rd(1'b0, 8'h00);
    // Masked level 3 pends, and enters service only once unmasked
    wr(1'b1, 8'h08);
    request_inputs = 8'h08;
    repeat (6) @(posedge clk);
    #1;
    chk({7'h00, int_req}, 8'h00);
    wr(1'b0, 8'h0a);
    rd(1'b0, 8'h08);
    wr(1'b0, 8'h0e);  // Poll and status enable both set
    rd(1'b0, 8'h83);
    ack(1'b0);
    chk(vec_val, 8'h47);  // No winner gives level 7
    wr(1'b0, 8'h0b);
    rd(1'b0, 8'h00);
    wr(1'b1, 8'h00);
    wait_int(1'b1);
    ack(1'b0);
    chk(vec_val, 8'h43);
    wr(1'b0, 8'h20);
    // Cascade level 2 with a slow processor
    request_inputs = 8'h04;
    wait_int(1'b1);
    ack(1'b1);
    chk({7'h00, casc_seen}, 8'h01);
    chk({5'h00, casc_addr}, 8'h02);
    chk({7'h00, vec_seen}, 8'h00);
    chk(vec_val, 8'he2);
    wr(1'b0, 8'h20);
    request_inputs = 8'h00;
    // Re-init: skip cascade word, level mode, self finish
    wr(1'b1, 8'h10);
    wr(1'b0, 8'h1b);
    wr(1'b1, 8'h88);
    wr(1'b1, 8'h02);  // Lands as options
    rd(1'b1, 8'h00);
    request_inputs = 8'h01;
    wait_int(1'b1);
    rd(1'b0, 8'h01);
    ack(1'b0);
    chk(vec_val, 8'h88);
    chk({7'h00, casc_seen}, 8'h00);
    wr(1'b0, 8'h0b);
    rd(1'b0, 8'h00);
    request_inputs = 8'h00;
    repeat (3) @(posedge clk);
    wr(1'b0, 8'h0a);
    rd(1'b0, 8'h00);
    wr(1'b0, 8'h0c);
    rd(1'b0, 8'h07);
    // Level 2 made lowest: level 4 now outranks level 0
    wr(1'b0, 8'hc2);
    request_inputs = 8'h11;
    rd(1'b0, 8'h84);
    request_inputs = 8'h00;
    // Short init: no cascade word, no options word
    wr(1'b0, 8'h12);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h5a);  // Lands as mask only once ready
    rd(1'b1, 8'h5a);
    close_out();
  end
endmodule
